// ===== shared/pwr_cond_pkg.sv
// Package: subcommand codes, register fields, limits and status layouts
package pwr_cond_pkg;
   localparam int          NUM_COND       = 4;
   localparam int          COND_W         = 2;
   localparam logic [3:0]  SUB_SET_TIMER  = 4'h2;
   localparam logic [3:0]  SUB_SET_STATE  = 4'h3;
   localparam logic [3:0]  SUB_ENABLE     = 4'h4;
   localparam int          SN_UNITS_BIT   = 7;
   localparam int          SN_ENABLE_BIT  = 5;
   localparam int          SN_SAVE_BIT    = 4;
   localparam logic [23:0] TIMER_MAX      = 24'h3BFFC4;
   localparam logic [23:0] TIMER_MIN      = 24'h000000;
   localparam int          TIMER_UNIT_MS  = 100;
   localparam int          MINUTE_MS      = 60000;
   localparam logic [23:0] MINUTE_SCALE   = 24'(MINUTE_MS / TIMER_UNIT_MS);
   localparam int          ERR_ABORT_BIT  = 2;
   localparam int          ST_BUSY_BIT    = 7;
   localparam int          ST_READY_BIT   = 6;
   localparam int          ST_FAULT_BIT   = 5;
   localparam int          ST_ERROR_BIT   = 0;
   localparam logic [7:0]  STATUS_RESET   = 8'h40;
   localparam logic [7:0]  ERROR_RESET    = 8'h00;
   localparam int          ID120_EPC_BIT  = 7;
   // Register-port offsets
   localparam logic [3:0]  OFF_ERROR      = 4'h0;
   localparam logic [3:0]  OFF_STATUS     = 4'h1;
   localparam logic [3:0]  OFF_IRQ_STAT   = 4'h2;
   localparam logic [3:0]  OFF_IRQ_MASK   = 4'h3;
   localparam logic [3:0]  OFF_FEATURE    = 4'h4;
   localparam logic [3:0]  OFF_CUR_TIMER  = 4'h5;
   localparam logic [3:0]  OFF_SAVED_TMR  = 4'h6;
   localparam logic [3:0]  OFF_ENABLES    = 4'h7;
   localparam logic [3:0]  OFF_SELECT     = 4'h8;
   localparam int          IRQ_DONE_BIT   = 0;
   localparam int          IRQ_ABORT_BIT  = 1;

   typedef struct packed {
      logic [7:0]  sector_count;
      logic [7:0]  sector_number;
      logic [15:0] timer;
   } cmd_t;

   typedef struct packed {
      logic supported;
      logic changeable;
      logic savable;
   } caps_t;
endpackage

// ===== design/timer_clamp.sv
// Timer value scaling and clamping into the 100 ms setting range
`timescale 1ns/1ns
module timer_clamp (
   input  wire logic [15:0] raw,
   input  wire logic        minute_units,
   output logic      [23:0] value,
   output logic             out_of_range
);
   logic [25:0] scaled;

   always_comb begin
      // A 16-bit count in minutes needs 26 bits; a narrower product wraps below the maximum
      scaled = minute_units ? 26'(raw) * 26'(pwr_cond_pkg::MINUTE_SCALE) : {10'h0, raw};
      out_of_range = (scaled > 26'(pwr_cond_pkg::TIMER_MAX)) ||
                     (scaled < 26'(pwr_cond_pkg::TIMER_MIN));
      if (scaled > 26'(pwr_cond_pkg::TIMER_MAX)) begin
         value = pwr_cond_pkg::TIMER_MAX;
      end else if (scaled < 26'(pwr_cond_pkg::TIMER_MIN)) begin
         value = pwr_cond_pkg::TIMER_MIN;
      end else begin
         value = scaled[23:0];
      end
   end
endmodule

// ===== design/power_condition_subcommand_handler.sv
// Power condition subcommand handler: timer-set, state-set, feature-enable
//
// Contract
// - Clamp 16-bit timer into min..max range
// - Max setting 3BFFC4h, minimum zero
// - Abort timer-set on listed failure cases
// - Abort leaves stored settings unchanged
// - State-set writes current enabled flag
// - State-set with save copies enabled flag
// - Abort state-set on listed failure cases
// - Enable sets feature, word120 bit7, disables APM
// - Enable loads current from saved or default
// - Start timer only if nonzero and enabled
// - Feature enable survives all resets
// - Abort feature-enable only when unsupported
// - Sector number bit 7 picks timer units
// - Timer-set enable follows nonzero value
`timescale 1ns/1ns
module power_condition_subcommand_handler #(
   parameter logic [23:0] DEFAULT_TIMER = 24'h000064,
   parameter logic        FEATURE_SUPPORTED = 1'b1
) (
   input  wire logic                 CLK,
   input  wire logic                 SYS_RST,
   input  wire logic                 CMD_VALID,
   input  wire pwr_cond_pkg::cmd_t   CMD,
   input  wire pwr_cond_pkg::caps_t  CAPS,
   input  wire logic [3:0]           REG_ADDR,
   input  wire logic [31:0]          REG_WDATA,
   input  wire logic                 REG_WR,
   input  wire logic                 REG_RD,
   output logic      [31:0]          REG_RDATA,
   output logic      [7:0]           ERROR_FLAGS,
   output logic      [7:0]           DEVICE_STATUS,
   output logic                      CMD_DONE,
   output logic                      FEATURE_ON,
   output logic                      ID120_BIT7,
   output logic                      APM_OFF,
   output logic [3:0]                TIMER_START,
   output logic                      IRQ
);
   localparam int N = pwr_cond_pkg::NUM_COND;

   logic [23:0]      cur_timer   [N];
   logic [23:0]      saved_timer [N];
   logic [N-1:0]     cur_en;
   logic [N-1:0]     saved_en;
   logic             feature_on = 1'b0;
   logic             apm_off;
   logic [7:0]       error_flags;
   logic [7:0]       device_status;
   logic             done;
   logic [N-1:0]     start;
   logic [1:0]       irq_stat;
   logic [1:0]       irq_mask;
   logic [31:0]      rdata;
   logic [1:0]       sel;

   logic [23:0]      next_cur_timer   [N];
   logic [23:0]      next_saved_timer [N];
   logic [N-1:0]     next_cur_en;
   logic [N-1:0]     next_saved_en;
   logic             next_feature_on;
   logic             next_apm_off;
   logic [7:0]       next_error_flags;
   logic [7:0]       next_device_status;
   logic             next_done;
   logic [N-1:0]     next_start;
   logic [1:0]       next_irq_stat;
   logic [1:0]       next_irq_mask;
   logic [31:0]      next_rdata;
   logic [1:0]       next_sel;

   logic [23:0]      clamped;
   logic             out_of_range;
   logic [3:0]       code;
   logic [1:0]       cond;
   logic             cond_ok;
   logic             abort;
   logic             ok;
   logic             want_en;
   logic             want_save;

   timer_clamp u_clamp (
      .raw          (CMD.timer),
      .minute_units (CMD.sector_number[pwr_cond_pkg::SN_UNITS_BIT]),
      .value        (clamped),
      .out_of_range (out_of_range)
   );

   always_comb begin
      code      = CMD.sector_number[3:0];
      cond      = CMD.sector_count[pwr_cond_pkg::COND_W-1:0];
      // Condition ids beyond the table count as unsupported
      cond_ok   = (CMD.sector_count < 8'(N)) && CAPS.supported && CAPS.changeable;
      want_en   = CMD.sector_number[pwr_cond_pkg::SN_ENABLE_BIT];
      want_save = CMD.sector_number[pwr_cond_pkg::SN_SAVE_BIT];
      // Clamping always succeeds here, so the unclamped case never aborts
      case (code)
         pwr_cond_pkg::SUB_SET_TIMER: abort = !feature_on || !cond_ok ||
                                              (want_save && !CAPS.savable);
         pwr_cond_pkg::SUB_SET_STATE: abort = !feature_on || !cond_ok ||
                                              (want_save && !CAPS.savable);
         pwr_cond_pkg::SUB_ENABLE:    abort = !FEATURE_SUPPORTED;
         default:                     abort = 1'b1;
      endcase
      ok = CMD_VALID && !abort;
   end

   always_comb begin
      next_cur_timer   = cur_timer;
      next_saved_timer = saved_timer;
      next_cur_en      = cur_en;
      next_saved_en    = saved_en;
      next_feature_on  = feature_on;
      next_apm_off     = apm_off;
      next_error_flags = error_flags;
      next_device_status = device_status;
      next_done        = CMD_VALID;
      next_start       = '0;
      next_irq_stat    = irq_stat;
      next_irq_mask    = irq_mask;
      next_sel         = sel;
      if (CMD_VALID) begin
         next_error_flags = ERROR_FLAGS_OF(abort);
         next_device_status = STATUS_OF(abort);
      end
      if (ok) begin
         case (code)
            pwr_cond_pkg::SUB_SET_TIMER: begin
               next_cur_timer[cond] = clamped;
               next_cur_en[cond] = want_en && (clamped != 24'h000000);
               if (want_save) begin
                  next_saved_timer[cond] = clamped;
                  next_saved_en[cond] = want_en && (clamped != 24'h000000);
               end
            end
            pwr_cond_pkg::SUB_SET_STATE: begin
               next_cur_en[cond] = want_en;
               if (want_save) begin
                  next_saved_en[cond] = want_en;
               end
            end
            pwr_cond_pkg::SUB_ENABLE: begin
               next_feature_on = 1'b1;
               next_apm_off = 1'b1;
               for (int i = 0; i < N; i++) begin
                  next_cur_timer[i] = (saved_timer[i] == 24'h000000) ?
                                      DEFAULT_TIMER : saved_timer[i];
                  next_start[i] = (next_cur_timer[i] != 24'h000000) && cur_en[i];
               end
            end
            default: begin
            end
         endcase
      end
      if (REG_WR && REG_ADDR == pwr_cond_pkg::OFF_IRQ_STAT) begin
         next_irq_stat = irq_stat & ~REG_WDATA[1:0];
      end
      if (REG_WR && REG_ADDR == pwr_cond_pkg::OFF_IRQ_MASK) begin
         next_irq_mask = REG_WDATA[1:0];
      end
      if (REG_WR && REG_ADDR == pwr_cond_pkg::OFF_SELECT) begin
         next_sel = REG_WDATA[1:0];
      end
      // Events win over a clear in the same cycle
      if (CMD_VALID) begin
         next_irq_stat[pwr_cond_pkg::IRQ_DONE_BIT] = 1'b1;
         if (abort) begin
            next_irq_stat[pwr_cond_pkg::IRQ_ABORT_BIT] = 1'b1;
         end
      end
      next_rdata = 32'h00000000;
      if (REG_RD) begin
         case (REG_ADDR)
            pwr_cond_pkg::OFF_ERROR:     next_rdata = {24'h000000, error_flags};
            pwr_cond_pkg::OFF_STATUS:    next_rdata = {24'h000000, device_status};
            pwr_cond_pkg::OFF_IRQ_STAT:  next_rdata = {30'h00000000, irq_stat};
            pwr_cond_pkg::OFF_IRQ_MASK:  next_rdata = {30'h00000000, irq_mask};
            pwr_cond_pkg::OFF_FEATURE:   next_rdata = {29'h00000000, apm_off, feature_on,
                                                        feature_on};
            pwr_cond_pkg::OFF_CUR_TIMER: next_rdata = {8'h00, cur_timer[sel]};
            pwr_cond_pkg::OFF_SAVED_TMR: next_rdata = {8'h00, saved_timer[sel]};
            pwr_cond_pkg::OFF_ENABLES:   next_rdata = {24'h000000, saved_en, cur_en};
            pwr_cond_pkg::OFF_SELECT:    next_rdata = {30'h00000000, sel};
            default:                     next_rdata = 32'h00000000;
         endcase
      end
   end

   function automatic logic [7:0] ERROR_FLAGS_OF(input logic ab);
      logic [7:0] e;
      e = 8'h00;
      e[pwr_cond_pkg::ERR_ABORT_BIT] = ab;
      return e;
   endfunction

   function automatic logic [7:0] STATUS_OF(input logic ab);
      logic [7:0] s;
      s = 8'h00;
      s[pwr_cond_pkg::ST_READY_BIT] = 1'b1;
      s[pwr_cond_pkg::ST_ERROR_BIT] = ab;
      return s;
   endfunction

   // Feature flag models nonvolatile state: SYS_RST never clears it
   always_ff @(posedge CLK) begin
      feature_on <= next_feature_on;
   end

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         for (int i = 0; i < N; i++) begin
            cur_timer[i]   <= 24'h000000;
            saved_timer[i] <= 24'h000000;
         end
         cur_en        <= '0;
         saved_en      <= '0;
         apm_off       <= 1'b0;
         error_flags   <= pwr_cond_pkg::ERROR_RESET;
         device_status <= pwr_cond_pkg::STATUS_RESET;
         done          <= 1'b0;
         start         <= '0;
         irq_stat      <= 2'h0;
         irq_mask      <= 2'h0;
         rdata         <= 32'h00000000;
         sel           <= 2'h0;
      end else begin
         cur_timer     <= next_cur_timer;
         saved_timer   <= next_saved_timer;
         cur_en        <= next_cur_en;
         saved_en      <= next_saved_en;
         apm_off       <= next_apm_off;
         error_flags   <= next_error_flags;
         device_status <= next_device_status;
         done          <= next_done;
         start         <= next_start;
         irq_stat      <= next_irq_stat;
         irq_mask      <= next_irq_mask;
         rdata         <= next_rdata;
         sel           <= next_sel;
      end
   end

   assign REG_RDATA     = rdata;
   assign ERROR_FLAGS   = error_flags;
   assign DEVICE_STATUS = device_status;
   assign CMD_DONE      = done;
   assign FEATURE_ON    = feature_on;
   assign ID120_BIT7    = feature_on;
   assign APM_OFF       = apm_off;
   assign TIMER_START   = start;
   assign IRQ           = |(irq_stat & irq_mask);

   sequence timer_cmd_s;
      CMD_VALID && code == pwr_cond_pkg::SUB_SET_TIMER && !abort;
   endsequence

   clamp_max_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      timer_cmd_s ##0 out_of_range |=> cur_timer[$past(cond)] == pwr_cond_pkg::TIMER_MAX)
      else $error("out-of-range timer not clamped");
   max_value_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      timer_cmd_s ##0 (CMD.sector_number[7] && CMD.timer == 16'hFFFF)
      |=> cur_timer[$past(cond)] == 24'h3BFFC4)
      else $error("maximum timer not stored");
   abort_keep_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      CMD_VALID && abort |=> $stable(cur_en) && $stable(saved_en))
      else $error("abort changed settings");
   timer_abort_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      CMD_VALID && code == pwr_cond_pkg::SUB_SET_TIMER && !feature_on
      |=> error_flags[pwr_cond_pkg::ERR_ABORT_BIT])
      else $error("timer-set not aborted");
   state_set_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      CMD_VALID && code == pwr_cond_pkg::SUB_SET_STATE && !abort
      |=> cur_en[$past(cond)] == $past(want_en))
      else $error("state-set flag wrong");
   state_save_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      CMD_VALID && code == pwr_cond_pkg::SUB_SET_STATE && !abort && want_save
      |=> saved_en[$past(cond)] == cur_en[$past(cond)])
      else $error("saved flag not copied");
   state_abort_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      CMD_VALID && code == pwr_cond_pkg::SUB_SET_STATE && want_save && !CAPS.savable
      |=> DEVICE_STATUS[pwr_cond_pkg::ST_ERROR_BIT])
      else $error("state-set not aborted");
   enable_on_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      CMD_VALID && code == pwr_cond_pkg::SUB_ENABLE && FEATURE_SUPPORTED
      |=> FEATURE_ON && ID120_BIT7 && APM_OFF)
      else $error("feature enable incomplete");
   enable_load_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      CMD_VALID && code == pwr_cond_pkg::SUB_ENABLE && !abort && saved_timer[0] == 24'h0
      |=> cur_timer[0] == DEFAULT_TIMER)
      else $error("default not loaded");
   for (genvar g = 0; g < N; g++) begin : gen_start
      start_gate_a: assert property (@(posedge CLK) disable iff (SYS_RST)
         TIMER_START[g] |-> cur_timer[g] != 24'h000000 && cur_en[g])
         else $error("timer started while idle");
   end
   timer_en_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      timer_cmd_s ##0 (CMD.timer == 16'h0000) |=> !cur_en[$past(cond)])
      else $error("zero timer left enabled");
   abort_flags_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      CMD_VALID |=> ERROR_FLAGS[pwr_cond_pkg::ERR_ABORT_BIT] ==
                    DEVICE_STATUS[pwr_cond_pkg::ST_ERROR_BIT] &&
                    !DEVICE_STATUS[pwr_cond_pkg::ST_BUSY_BIT] &&
                    !DEVICE_STATUS[pwr_cond_pkg::ST_FAULT_BIT])
      else $error("abort and error bits disagree");
endmodule

// ===== dv/host_model.sv
// Host-side model that presents set-features subcommands to the handler
`timescale 1ns/1ns
module host_model (
   input  wire logic           clk,
   output logic                cmd_valid,
   output pwr_cond_pkg::cmd_t  cmd,
   output pwr_cond_pkg::caps_t caps
);
   initial begin
      cmd_valid = 1'b0;
      cmd       = '0;
      caps      = '0;
   end

   // Fields are inverted once the strobe drops so no stale value looks valid
   task automatic issue(input logic [3:0] code, input logic [7:0] cond,
                        input logic [2:0] flags, input logic [15:0] timer,
                        input logic [2:0] cap);
      @(posedge clk);
      cmd_valid         <= 1'b1;
      cmd.sector_count  <= cond;
      cmd.sector_number <= {flags[2], 1'b0, flags[1:0], code};
      cmd.timer         <= timer;
      caps              <= cap;
      @(posedge clk);
      cmd_valid <= 1'b0;
      cmd       <= ~cmd;
      caps      <= ~caps;
   endtask
endmodule

// ===== dv/testbench.sv
// Self-checking bench for the power condition subcommand handler
`timescale 1ns/1ns
module testbench;
   localparam logic [23:0] DEF_T = 24'h000055;
   typedef struct packed {
      logic [3:0]  code;
      logic [2:0]  flags;
      logic [15:0] timer;
      logic [2:0]  caps;
      logic        abort;
      logic [23:0] cur;
      logic [7:0]  ens;
   } row_t;

   logic                clk;
   logic                sys_rst;
   logic                cmd_valid;
   pwr_cond_pkg::cmd_t  cmd;
   pwr_cond_pkg::caps_t caps;
   logic [3:0]          addr;
   logic [31:0]         wdata;
   logic                wr;
   logic                rd;
   logic [31:0]         rdata;
   logic [7:0]          err_flags;
   logic [7:0]          dev_status;
   logic                cmd_done;
   logic                feat_on;
   logic                id120;
   logic                apm_off;
   logic [3:0]          t_start;
   logic                irq;
   int                  n_errors = 0;
   int                  checks_done = 0;
   row_t                rows [13];

   host_model host (.clk(clk), .cmd_valid(cmd_valid), .cmd(cmd), .caps(caps));

   power_condition_subcommand_handler #(.DEFAULT_TIMER(DEF_T), .FEATURE_SUPPORTED(1'b1)) uut (
      .CLK(clk), .SYS_RST(sys_rst), .CMD_VALID(cmd_valid), .CMD(cmd), .CAPS(caps),
      .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
      .ERROR_FLAGS(err_flags), .DEVICE_STATUS(dev_status), .CMD_DONE(cmd_done),
      .FEATURE_ON(feat_on), .ID120_BIT7(id120), .APM_OFF(apm_off), .TIMER_START(t_start),
      .IRQ(irq));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic wrap_up;
      $display("checks %0d, mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   initial begin
      #(4000 * 8);
      n_errors++;
      $display("mismatch at %0t: watchdog expired", $time);
      wrap_up;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: %s got %0h expected %0h", $time, what, got, exp);
      end
   endtask

   task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input string what);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdata, exp, what);
   endtask

   task automatic do_cmd(input logic [3:0] code, input logic [2:0] flags,
                         input logic [15:0] timer, input logic [2:0] cap, input logic ab);
      host.issue(code, 8'h01, flags, timer, cap);
      #1;
      chk(32'(cmd_done), 32'h1, "done pulse");
      chk(32'(err_flags), ab ? 32'h4 : 32'h0, "error flags");
      chk(32'(dev_status), ab ? 32'h41 : 32'h40, "status");
   endtask

   initial begin
      sys_rst = 1'b1;
      addr    = '0;
      wdata   = '0;
      wr      = 1'b0;
      rd      = 1'b0;
      rows = '{
         '{4'h2, 3'h2, 16'h1234, 3'h7, 1'h0, 24'h001234, 8'h02},
         '{4'h2, 3'h7, 16'hFFFF, 3'h7, 1'h0, 24'h3BFFC4, 8'h22},
         '{4'h2, 3'h2, 16'h0000, 3'h7, 1'h0, 24'h000000, 8'h20},
         '{4'h3, 3'h2, 16'h0000, 3'h7, 1'h0, 24'h000000, 8'h22},
         '{4'h3, 3'h1, 16'h0000, 3'h7, 1'h0, 24'h000000, 8'h00},
         '{4'h3, 3'h3, 16'h0000, 3'h6, 1'h1, 24'h000000, 8'h00},
         '{4'h3, 3'h2, 16'h0000, 3'h5, 1'h1, 24'h000000, 8'h00},
         '{4'h3, 3'h2, 16'h0000, 3'h3, 1'h1, 24'h000000, 8'h00},
         '{4'h2, 3'h3, 16'h0055, 3'h6, 1'h1, 24'h000000, 8'h00},
         '{4'h2, 3'h2, 16'h0055, 3'h5, 1'h1, 24'h000000, 8'h00},
         '{4'h3, 3'h3, 16'h0000, 3'h7, 1'h0, 24'h000000, 8'h22},
         '{4'h2, 3'h6, 16'h7000, 3'h7, 1'h0, 24'h3BFFC4, 8'h22},
         '{4'h2, 3'h6, 16'h0010, 3'h7, 1'h0, 24'h002580, 8'h22}};
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      #1;
      chk(32'(dev_status), 32'h40, "status after reset");
      chk(32'(feat_on), 32'h0, "feature after power-up");
      $display("test reset done");
      reg_wr(pwr_cond_pkg::OFF_SELECT, 32'h1);
      do_cmd(pwr_cond_pkg::SUB_SET_TIMER, 3'h2, 16'h0010, 3'h7, 1'b1);
      do_cmd(pwr_cond_pkg::SUB_SET_STATE, 3'h2, 16'h0000, 3'h7, 1'b1);
      do_cmd(4'h7, 3'h2, 16'h0000, 3'h7, 1'b1);
      $display("test feature off done");
      // Caps all clear: enable must still succeed
      do_cmd(pwr_cond_pkg::SUB_ENABLE, 3'h0, 16'h0000, 3'h0, 1'b0);
      chk(32'(t_start), 32'h0, "no timer start");
      chk(32'({feat_on, id120, apm_off}), 32'h7, "feature outputs");
      rd_chk(pwr_cond_pkg::OFF_CUR_TIMER, 32'(DEF_T), "default load");
      rd_chk(pwr_cond_pkg::OFF_FEATURE, 32'h7, "feature register");
      $display("test enable done");
      foreach (rows[i]) begin
         do_cmd(rows[i].code, rows[i].flags, rows[i].timer,
                rows[i].caps, rows[i].abort);
         rd_chk(pwr_cond_pkg::OFF_CUR_TIMER, 32'(rows[i].cur), "current timer");
         rd_chk(pwr_cond_pkg::OFF_ENABLES, 32'(rows[i].ens), "enabled flags");
      end
      rd_chk(pwr_cond_pkg::OFF_SAVED_TMR, 32'(pwr_cond_pkg::TIMER_MAX), "saved timer");
      $display("test table done");
      do_cmd(pwr_cond_pkg::SUB_ENABLE, 3'h0, 16'h0000, 3'h7, 1'b0);
      chk(32'(t_start), 32'h2, "timer start");
      rd_chk(pwr_cond_pkg::OFF_CUR_TIMER, 32'(pwr_cond_pkg::TIMER_MAX), "saved load");
      $display("test re-enable done");
      chk(32'(irq), 32'h0, "irq masked");
      rd_chk(pwr_cond_pkg::OFF_IRQ_STAT, 32'h3, "irq status");
      reg_wr(pwr_cond_pkg::OFF_IRQ_MASK, 32'h2);
      #1;
      chk(32'(irq), 32'h1, "irq raised");
      reg_wr(pwr_cond_pkg::OFF_IRQ_STAT, 32'h2);
      #1;
      chk(32'(irq), 32'h0, "irq cleared");
      rd_chk(pwr_cond_pkg::OFF_IRQ_STAT, 32'h1, "irq status after clear");
      rd_chk(4'hF, 32'h0, "unmapped read");
      $display("test irq done");
      @(posedge clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk(32'(feat_on), 32'h1, "feature through reset");
      @(posedge clk);
      sys_rst <= 1'b0;
      #1;
      chk(32'(dev_status), 32'h40, "status after second reset");
      $display("test mid-run reset done");
      wrap_up;
   end
endmodule
